// *** tcw_consts.svh ***
// constants for the timer compare waveform core
`ifndef TCW_CONSTS_SVH
`define TCW_CONSTS_SVH

// =====================================================================
// register byte offsets
`define TCW_OFS_CONTROL_ONE   8'h00
`define TCW_OFS_CONTROL_TWO   8'h04
`define TCW_OFS_CONTROL_FIVE  8'h08
`define TCW_OFS_CONTROL_SIX   8'h0c
`define TCW_OFS_EVENT_CONTROL 8'h10
`define TCW_OFS_FLAGS         8'h14
`define TCW_OFS_COUNT_VALUE   8'h18
`define TCW_OFS_PERIOD        8'h1c
`define TCW_OFS_PERIOD_BUFFER 8'h20
`define TCW_OFS_COMPARE_BASE  8'h24
`define TCW_OFS_CMPBUF_BASE   8'h30

// =====================================================================
// field positions
`define TCW_BIT_ENABLE        0
`define TCW_LSB_PRESCALE      1
`define TCW_LSB_CMP_EN        4
`define TCW_BIT_DIR_DOWN      0
`define TCW_BIT_PER_BV        0
`define TCW_LSB_CMP_BV        1
`define TCW_BIT_CNT_ON_EVENT  0
`define TCW_BIT_TOP_FLAG      0
`define TCW_LSB_MATCH_FLAG    4

// =====================================================================
// reset values
`define TCW_RST_PERIOD        16'hffff
`define TCW_RST_ZERO16        16'h0000

// =====================================================================
// prescaler divider exponents for settings 0..7
`define TCW_PSC_SHIFTS        {4'ha, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
`define TCW_PSC_WIDTH         10

`endif

// *** tcw_core.sv ***
// timer compare waveform core with apb registers
// =====================================================================
`timescale 1ns/1ps
`include "tcw_consts.svh"

module tcw_core
   import tcw_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   input  wire logic        i_event,
   input  wire logic [2:0]  i_port_out,
   input  wire logic [2:0]  i_port_alt_out,
   input  wire logic [2:0]  i_pin_route,
   output logic [2:0]       o_pin_out,
   output logic [2:0]       o_pin_alt_out
);

   // ==================================================================
   // state
   logic              enable_q;
   logic [2:0]        prescale_q;
   tcw_waveform_mode_select_t       mode_q;
   logic [2:0]        cmp_en_q;
   logic              dir_down_q;
   logic              cnt_ev_q;
   logic              top_flag_q;
   logic [2:0]        match_flag_q;
   tcw_word_t         cnt_q;
   tcw_word_t         per_q;
   tcw_word_t         period_buffer_q;
   logic              per_bv_q;
   tcw_word_t         cmp_q    [3];
   tcw_word_t         cmpbuf_q [3];
   logic [2:0]        cmp_bv_q;
   logic [2:0]        wg_q;
   logic              event_q;
   logic              pready_q;
   logic [31:0]       prdata_q;
   logic              pslverr_q;

   // ==================================================================
   // bus decode
   logic        wr;
   logic        rd_known;
   logic [31:0] rdata;
   logic        wr_cnt;
   logic        wr_per;
   logic        wr_period_buffer;
   logic [2:0]  wr_cmp;
   logic [2:0]  wr_cmpbuf;
   logic        wr_flags;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // write takes effect only at the edge where the slave answers
   assign wr        = i_psel && i_penable && i_pwrite && pready_q;
   assign wr_cnt    = wr && hit(i_paddr, `TCW_OFS_COUNT_VALUE);
   assign wr_per    = wr && hit(i_paddr, `TCW_OFS_PERIOD);
   assign wr_period_buffer = wr && hit(i_paddr, `TCW_OFS_PERIOD_BUFFER);
   assign wr_flags  = wr && hit(i_paddr, `TCW_OFS_FLAGS);

   always_comb begin
      for (int n = 0; n < 3; n++) begin
         wr_cmp[n]    = wr && hit(i_paddr,
                        8'(`TCW_OFS_COMPARE_BASE + 4 * n));
         wr_cmpbuf[n] = wr && hit(i_paddr,
                        8'(`TCW_OFS_CMPBUF_BASE + 4 * n));
      end
   end

   always_comb begin
      rdata    = 32'h0000_0000;
      rd_known = 1'b1;
      case (i_paddr)
         `TCW_OFS_CONTROL_ONE:   rdata = {28'h000_0000, prescale_q, enable_q};
         `TCW_OFS_CONTROL_TWO:   rdata = {25'h000_0000, cmp_en_q, 1'b0,
                                          mode_q};
         `TCW_OFS_CONTROL_FIVE:  rdata = {31'h0000_0000, dir_down_q};
         `TCW_OFS_CONTROL_SIX:   rdata = {28'h000_0000, cmp_bv_q, per_bv_q};
         `TCW_OFS_EVENT_CONTROL: rdata = {31'h0000_0000, cnt_ev_q};
         `TCW_OFS_FLAGS:         rdata = {25'h000_0000, match_flag_q, 3'h0,
                                          top_flag_q};
         `TCW_OFS_COUNT_VALUE:   rdata = {16'h0000, cnt_q};
         `TCW_OFS_PERIOD:        rdata = {16'h0000, per_q};
         `TCW_OFS_PERIOD_BUFFER: rdata = {16'h0000, period_buffer_q};
         8'h24:                  rdata = {16'h0000, cmp_q[0]};
         8'h28:                  rdata = {16'h0000, cmp_q[1]};
         8'h2c:                  rdata = {16'h0000, cmp_q[2]};
         8'h30:                  rdata = {16'h0000, cmpbuf_q[0]};
         8'h34:                  rdata = {16'h0000, cmpbuf_q[1]};
         8'h38:                  rdata = {16'h0000, cmpbuf_q[2]};
         default:                rd_known = 1'b0;
      endcase
   end

   // one wait state: data is captured into flops at the edge where pready rises
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (i_ce) begin
         if (i_psel && i_penable && !pready_q) begin
            pready_q  <= 1'b1;
            prdata_q  <= i_pwrite ? 32'h0000_0000 : rdata;
            pslverr_q <= !rd_known;
         end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   assign o_pready  = pready_q;
   assign o_prdata  = prdata_q;
   assign o_pslverr = pslverr_q;

   // ==================================================================
   // control registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         enable_q   <= 1'b0;
         prescale_q <= 3'h0;
         mode_q     <= TCW_WG_NORMAL;
         cmp_en_q   <= 3'h0;
         dir_down_q <= 1'b0;
         cnt_ev_q   <= 1'b0;
      end else if (i_ce && wr) begin
         case (i_paddr)
            `TCW_OFS_CONTROL_ONE: begin
               enable_q   <= i_pwdata[`TCW_BIT_ENABLE];
               prescale_q <= i_pwdata[`TCW_LSB_PRESCALE +: 3];
            end
            `TCW_OFS_CONTROL_TWO: begin
               mode_q   <= tcw_waveform_mode_select_t'(i_pwdata[2:0]);
               cmp_en_q <= i_pwdata[`TCW_LSB_CMP_EN +: 3];
            end
            `TCW_OFS_CONTROL_FIVE: dir_down_q <= i_pwdata[`TCW_BIT_DIR_DOWN];
            `TCW_OFS_EVENT_CONTROL: cnt_ev_q <= i_pwdata[`TCW_BIT_CNT_ON_EVENT];
            default: ;
         endcase
      end
   end

   // ==================================================================
   // tick source
   logic psc_tick;
   logic tick;
   logic ev_rise;

   tcw_prescale u_prescale (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .i_run  (enable_q && !cnt_ev_q),
      .i_sel  (prescale_q),
      .o_tick (psc_tick)
   );

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         event_q <= 1'b0;
      end else if (i_ce) begin
         event_q <= i_event;
      end
   end

   assign ev_rise = i_event && !event_q;
   assign tick = enable_q && (cnt_ev_q ? ev_rise : psc_tick);

   // ==================================================================
   // counter
   logic      is_frq;
   logic      is_ss;
   logic      count_down;
   tcw_word_t top;
   logic      at_top;
   logic      at_bottom;
   logic      upd;
   logic [2:0] match;

   assign is_frq     = (mode_q == TCW_WG_FREQ);
   assign is_ss      = (mode_q == TCW_WG_SINGLE);
   // waveform modes run upward from bottom to top
   assign count_down = dir_down_q && !is_frq && !is_ss;
   // top is the period, or compare zero in frequency mode
   assign top        = is_frq ? cmp_q[0] : per_q;
   assign at_top     = (cnt_q == top);
   assign at_bottom  = (cnt_q == `TCW_RST_ZERO16);
   // update at top when up-counting, at bottom when down-counting
   assign upd        = tick && (count_down ? at_bottom : at_top);

   always_comb begin
      for (int n = 0; n < 3; n++) begin
         match[n] = (cnt_q == cmp_q[n]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= `TCW_RST_ZERO16;
      end else if (i_ce) begin
         if (wr_cnt) begin
            cnt_q <= i_pwdata[15:0];
         end else if (tick) begin
            if (count_down) begin
               cnt_q <= at_bottom ? per_q : cnt_q - 16'h0001;
            end else begin
               // wrap after top; above top runs past max
               cnt_q <= at_top ? `TCW_RST_ZERO16 : cnt_q + 16'h0001;
            end
         end
      end
   end

   // ==================================================================
   // period and buffer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         per_q    <= `TCW_RST_PERIOD;
         period_buffer_q <= `TCW_RST_PERIOD;
         per_bv_q <= 1'b0;
      end else if (i_ce) begin
         if (wr_per) begin
            per_q <= i_pwdata[15:0];
         end else if (upd && per_bv_q) begin
            per_q <= period_buffer_q;
         end
         if (wr_period_buffer) begin
            period_buffer_q <= i_pwdata[15:0];
         end
         // set wins over the update clear
         if (wr_period_buffer) begin
            per_bv_q <= 1'b1;
         end else if (upd) begin
            per_bv_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // compare channels
   // three channels each with buffer and flag
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int n = 0; n < 3; n++) begin
            cmp_q[n]    <= `TCW_RST_ZERO16;
            cmpbuf_q[n] <= `TCW_RST_ZERO16;
         end
         cmp_bv_q <= 3'h0;
      end else if (i_ce) begin
         for (int n = 0; n < 3; n++) begin
            // direct write, else buffer copy at update
            if (wr_cmp[n]) begin
               cmp_q[n] <= i_pwdata[15:0];
            end else if (upd && cmp_bv_q[n]) begin
               cmp_q[n] <= cmpbuf_q[n];
            end
            if (wr_cmpbuf[n]) begin
               cmpbuf_q[n] <= i_pwdata[15:0];
            end
            if (wr_cmpbuf[n]) begin
               cmp_bv_q[n] <= 1'b1;
            end else if (upd) begin
               cmp_bv_q[n] <= 1'b0;
            end
         end
      end
   end

   // flags are write-one-to-clear; a new event beats the clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         top_flag_q   <= 1'b0;
         match_flag_q <= 3'h0;
      end else if (i_ce) begin
         if (upd) begin
            top_flag_q <= 1'b1;
         end else if (wr_flags && i_pwdata[`TCW_BIT_TOP_FLAG]) begin
            top_flag_q <= 1'b0;
         end
         for (int n = 0; n < 3; n++) begin
            if (tick && match[n]) begin
               match_flag_q[n] <= 1'b1;
            end else if (wr_flags && i_pwdata[`TCW_LSB_MATCH_FLAG + n]) begin
               match_flag_q[n] <= 1'b0;
            end
         end
      end
   end

   // ==================================================================
   // waveform generation
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wg_q <= 3'h0;
      end else if (i_ce) begin
         for (int n = 0; n < 3; n++) begin
            if (is_frq) begin
               if (tick && match[n]) begin
                  wg_q[n] <= !wg_q[n];
               end
            end else if (is_ss) begin
               // match clear beats set when compare equals top
               if (tick && match[n]) begin
                  wg_q[n] <= 1'b0;
               end else if (tick && at_top) begin
                  wg_q[n] <= 1'b1;
               end
            end else begin
               wg_q[n] <= 1'b0;
            end
         end
      end
   end

   // pins are registered so the override changes cleanly on an edge
   logic [2:0] ovr;
   assign ovr = (mode_q != TCW_WG_NORMAL && !cnt_ev_q) ? cmp_en_q : 3'h0;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pin_out     <= 3'h0;
         o_pin_alt_out <= 3'h0;
      end else if (i_ce) begin
         for (int n = 0; n < 3; n++) begin
            // override port value, optionally on the alternate pin
            o_pin_out[n]     <= (ovr[n] && !i_pin_route[n]) ? wg_q[n]
                                : i_port_out[n];
            o_pin_alt_out[n] <= (ovr[n] && i_pin_route[n]) ? wg_q[n]
                                : i_port_alt_out[n];
         end
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_ce);

   cnt_idle_a: assert property (!enable_q && !wr_cnt |=> $stable(cnt_q))
      else $error("counter moved while disabled");
   cnt_wrap_a: assert property (tick && !count_down && at_top && !wr_cnt
      |=> cnt_q == 16'h0000) else $error("no wrap after top");
   cnt_reload_a: assert property (tick && count_down && at_bottom
      && !wr_cnt |=> cnt_q == $past(per_q)) else $error("no reload at bottom");
   cnt_write_a: assert property (wr_cnt
      |=> cnt_q == $past(i_pwdata[15:0])) else $error("counter write lost");
   per_valid_a: assert property (wr_period_buffer |=> per_bv_q
      ##0 period_buffer_q == $past(i_pwdata[15:0]))
      else $error("period buffer valid not set");
   per_hold_a: assert property (!upd && !wr_per |=> $stable(per_q))
      else $error("period changed outside update");
   cmp_load_a: assert property (upd && cmp_bv_q[0] && !wr_cmp[0]
      |=> cmp_q[0] == $past(cmpbuf_q[0]) && (!cmp_bv_q[0]
      || $past(wr_cmpbuf[0]))) else $error("compare buffer not loaded");
   match_flag_a: assert property (tick && match[2] |=> match_flag_q[2])
      else $error("match flag not set");
   frq_toggle_a: assert property (is_frq && tick && match[0]
      |=> wg_q[0] != $past(wg_q[0])) else $error("no toggle on match");
   ss_set_a: assert property (is_ss && tick && at_top && !match[1]
      |=> wg_q[1]) else $error("pwm output not set at top");
   pin_ovr_a: assert property (cnt_ev_q && $past(cnt_ev_q)
      |=> o_pin_out == $past(i_port_out)) else $error("override on events");

endmodule

// *** tcw_core_bench.sv ***
// self-checking testbench for the timer compare waveform core
`timescale 1ns/1ps
`include "tcw_consts.svh"

module tcw_core_bench;
   logic        clk = 1'b0;
   logic        rst, psel, penable, pwrite, pready, pslverr, ev, fire;
   logic        use_alt, pv, rerr, ce;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [2:0]  port_out, alt_out, route_in, pin_out, pin_alt;
   logic [2:0]  port_val, route;
   int          miscompares = 0;
   int          checked = 0;
   int          ch;

   always #12.5 clk = ~clk;
   assign pv = use_alt ? pin_alt[ch] : pin_out[ch];

   tcw_core dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_event(ev), .i_port_out(port_out),
      .i_port_alt_out(alt_out), .i_pin_route(route_in),
      .o_pin_out(pin_out), .o_pin_alt_out(pin_alt));

   tcw_port_model port_u (.i_clk(clk), .i_fire(fire), .i_port_val(port_val),
      .i_route(route), .o_event(ev), .o_port_out(port_out),
      .o_port_alt_out(alt_out), .o_pin_route(route_in));

   // =================================================================
   // compare and bus tasks
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      checked++;
      if (got != exp) begin
         miscompares++;
         $display("MISMATCH t=%0t cycles %0d expected %0d", $time, got, exp);
      end
   endtask

   // entered just after a rising edge, leaves just after one
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      chk_cyc(n, 2);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk_reg(rdata, exp);
   endtask

   task automatic pulse;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // syncs on a rising edge, skips one period, then times the next
   task automatic measure(input int hi_e, input int per_e);
      int h, p, n;
      logic last;
      h = 0;
      p = 0;
      n = 0;
      last = pv;
      while (n < 3000 && !(pv === 1'b1 && last === 1'b0)) begin
         last = pv;
         @(posedge clk);
         n++;
      end
      repeat (2) begin
         h = 0;
         p = 0;
         do begin
            if (pv === 1'b1) h++;
            p++;
            last = pv;
            @(posedge clk);
         end while (p < 3000 && !(pv === 1'b1 && last === 1'b0));
      end
      chk_cyc(h, hi_e);
      chk_cyc(p, per_e);
   endtask

   task automatic pin_hold(input logic [2:0] v);
      port_val <= v;
      repeat (3) @(posedge clk);
      chk_reg({29'h0, pin_out}, {29'h0, v});
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // =================================================================
   // test sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {psel, penable, pwrite, fire, use_alt} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      port_val = 3'h5;
      route = 3'h0;
      ch = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`TCW_OFS_CONTROL_ONE, 32'h0000_0000); // disabled at reset
      rd(`TCW_OFS_PERIOD, 32'h0000_ffff); // max period
      rd(`TCW_OFS_PERIOD_BUFFER, 32'h0000_ffff); // buffer reset value
      wr(`TCW_OFS_CONTROL_SIX, 32'h0000_000f);
      rd(`TCW_OFS_CONTROL_SIX, 32'h0000_0000); // read-only flags
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk_reg({31'h0, rerr}, 32'h0000_0001); // unmapped refused
      done("reset and map");
      wr(`TCW_OFS_EVENT_CONTROL, 32'h0000_0001);
      wr(`TCW_OFS_PERIOD, 32'h0000_0005);
      wr(`TCW_OFS_PERIOD_BUFFER, 32'h0000_0007);
      rd(`TCW_OFS_CONTROL_SIX, 32'h0000_0001); // flag set
      rd(`TCW_OFS_PERIOD, 32'h0000_0005); // no early load
      wr(`TCW_OFS_CMPBUF_BASE, 32'h0000_0009);
      wr(`TCW_OFS_COMPARE_BASE + 8'h04, 32'h0000_0002);
      rd(`TCW_OFS_COMPARE_BASE + 8'h04, 32'h0000_0002); // direct
      rd(`TCW_OFS_CONTROL_SIX, 32'h0000_0003); // per buffer
      wr(`TCW_OFS_COUNT_VALUE, 32'h0000_0005);
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0005); // direct write
      wr(`TCW_OFS_CONTROL_ONE, 32'h0000_0001);
      pulse();
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0000); // wrap
      rd(`TCW_OFS_PERIOD, 32'h0000_0007); // load at update
      rd(`TCW_OFS_COMPARE_BASE, 32'h0000_0009); // load at update
      rd(`TCW_OFS_CONTROL_SIX, 32'h0000_0000); // cleared
      rd(`TCW_OFS_FLAGS, 32'h0000_0001); // update at top
      wr(`TCW_OFS_FLAGS, 32'h0000_0071);
      rd(`TCW_OFS_FLAGS, 32'h0000_0000); // flags cleared
      repeat (3) pulse();
      rd(`TCW_OFS_FLAGS, 32'h0000_0060); // match flags
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0003); // counts events
      wr(`TCW_OFS_COUNT_VALUE, 32'h0000_000a);
      wr(`TCW_OFS_PERIOD, 32'h0000_0004);
      pulse();
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_000b); // runs past top
      wr(`TCW_OFS_CONTROL_FIVE, 32'h0000_0001);
      wr(`TCW_OFS_COUNT_VALUE, 32'h0000_0000);
      pulse();
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0004); // reload period
      pulse();
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0003); // counts down
      // clock enable low must swallow the event completely
      ce <= 1'b0;
      pulse();
      ce <= 1'b1;
      rd(`TCW_OFS_COUNT_VALUE, 32'h0000_0003); // frozen, no count
      wr(`TCW_OFS_CONTROL_FIVE, 32'h0000_0000);
      wr(`TCW_OFS_EVENT_CONTROL, 32'h0000_0000);
      done("counting and buffers");
      wr(`TCW_OFS_PERIOD, 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         wr(`TCW_OFS_COMPARE_BASE + 8'(4 * i), 32'(i));
      end
      wr(`TCW_OFS_CONTROL_TWO, 32'h0000_0073);
      for (int i = 0; i < 3; i++) begin
         ch = i;
         measure(i + 1, 4); // duty per channel
      end
      ch = 1;
      for (int s = 0; s < 4; s++) begin
         wr(`TCW_OFS_CONTROL_ONE, 32'(1 + 2 * s));
         measure(2 << s, 4 << s); // prescaled period
      end
      wr(`TCW_OFS_CONTROL_ONE, 32'h0000_0001);
      route <= 3'h2;
      use_alt <= 1'b1;
      @(posedge clk);
      measure(2, 4); // alternate pin
      route <= 3'h0;
      use_alt <= 1'b0;
      wr(`TCW_OFS_EVENT_CONTROL, 32'h0000_0001);
      pin_hold(3'h7); // no output on events
      pin_hold(3'h0); // port value shown
      wr(`TCW_OFS_EVENT_CONTROL, 32'h0000_0000);
      done("single slope");
      wr(`TCW_OFS_CONTROL_TWO, 32'h0000_0011);
      wr(`TCW_OFS_COMPARE_BASE, 32'h0000_0000);
      wr(`TCW_OFS_COUNT_VALUE, 32'h0000_0000);
      ch = 0;
      measure(1, 2); // half clock rate
      wr(`TCW_OFS_COMPARE_BASE, 32'h0000_0002);
      measure(3, 6); // toggle per match
      done("frequency");
      finish_test();
   end

   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      finish_test();
   end
endmodule

// *** tcw_pkg.sv ***
// types for the timer compare waveform core
package tcw_pkg;

   typedef enum logic [2:0] {
      TCW_WG_NORMAL = 3'h0,
      TCW_WG_FREQ   = 3'h1,
      TCW_WG_SINGLE = 3'h3
   } tcw_waveform_mode_select_t;

   typedef logic [15:0] tcw_word_t;

endpackage

// *** tcw_port_model.sv ***
// behavioural port pin logic and event source beside the timer core
`timescale 1ns/1ps

module tcw_port_model (
   input  wire logic       i_clk,
   input  wire logic       i_fire,
   input  wire logic [2:0] i_port_val,
   input  wire logic [2:0] i_route,
   output logic            o_event,
   output logic [2:0]      o_port_out,
   output logic [2:0]      o_port_alt_out,
   output logic [2:0]      o_pin_route
);
   logic [1:0] hold_q = 2'h0;

   // =================================================================
   // event source
   // held two cycles so one request gives exactly one rising edge
   always_ff @(posedge i_clk) begin
      if (i_fire) begin
         hold_q <= 2'h2;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end
   assign o_event = (hold_q != 2'h0);

   // =================================================================
   // port output registers and pin routing
   // alternate pins carry the inverse so the two never look alike
   assign o_port_out     = i_port_val;
   assign o_port_alt_out = ~i_port_val;
   assign o_pin_route    = i_route;
endmodule

// *** tcw_prescale.sv ***
// prescaler that turns the peripheral clock into timer ticks
`timescale 1ns/1ps
`include "tcw_consts.svh"

module tcw_prescale
   import tcw_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   input  wire logic       i_run,
   input  wire logic [2:0] i_sel,
   output logic            o_tick
);

   localparam logic [31:0] SHIFTS = `TCW_PSC_SHIFTS;

   logic [`TCW_PSC_WIDTH-1:0] div_q;
   logic [`TCW_PSC_WIDTH-1:0] mask;

   function automatic logic [`TCW_PSC_WIDTH-1:0] div_mask(
      input logic [2:0] sel);
      logic [3:0] sh;
      sh = SHIFTS[4*sel +: 4];
      div_mask = `TCW_PSC_WIDTH'((11'h001 << sh) - 11'h001);
   endfunction

   assign mask   = div_mask(i_sel);
   // stopped prescaler restarts aligned so the first tick is a full one
   assign o_tick = i_run && ((div_q & mask) == mask);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div_q <= '0;
      end else if (i_ce) begin
         if (!i_run) begin
            div_q <= '0;
         end else begin
            div_q <= div_q + `TCW_PSC_WIDTH'(1);
         end
      end
   end

endmodule
